//--- comparator_pkg.sv
// Purpose: Shared constants and types for the comparator output control block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Field positions follow the control/status word layout.

package comparator_pkg;

	// -------------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------------
	localparam logic [11:0] CS_OFFSET         = 12'h000;
	localparam logic [11:0] INT_STATUS_OFFSET = 12'h004;
	localparam logic [11:0] INT_CLEAR_OFFSET  = 12'h008;
	localparam logic [11:0] INT_ENABLE_OFFSET = 12'h00c;

	// -------------------------------------------------------------------
	// Control/status field positions and values
	// -------------------------------------------------------------------
	localparam int          LOCK_BIT        = 31;
	localparam int          STATE_BIT       = 30;
	localparam int          SCALER_EN_BIT   = 23;
	localparam int          BRIDGE_EN_BIT   = 22;
	localparam int          BLANK_LSB       = 18;
	localparam int          HYST_LSB        = 16;
	localparam int          POLARITY_BIT    = 15;
	localparam int          OUT_SEL_LSB     = 13;
	localparam int          PLUS_SEL_LSB    = 10;
	localparam int          MINUS_SEL_LSB   = 7;
	localparam int          MINUS_EXT_LSB   = 4;
	localparam int          SPEED_LSB       = 2;
	localparam int          ENABLE_BIT      = 0;
	localparam logic [31:0] CS_WRITE_MASK   = 32'h80dffffd;
	localparam logic [31:0] CS_RESET        = 32'h00000000;

	// -------------------------------------------------------------------
	// Field codes
	// -------------------------------------------------------------------
	localparam logic [2:0]  BLANK_NONE      = 3'h0;
	localparam logic [2:0]  BLANK_SRC_A     = 3'h1;
	localparam logic [2:0]  BLANK_SRC_B     = 3'h2;
	localparam logic [2:0]  BLANK_SRC_C     = 3'h3;
	localparam logic [1:0]  OUT_SEL_FIRST   = 2'h1;
	localparam logic [1:0]  OUT_SEL_SECOND  = 2'h2;

	// -------------------------------------------------------------------
	// Interrupt registers
	// -------------------------------------------------------------------
	localparam int          INT_WIDTH       = 2;
	localparam int          INT_RISE_BIT    = 0;
	localparam int          INT_FALL_BIT    = 1;
	localparam logic [1:0]  INT_RESET       = 2'h0;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int          SYNC_DELAY      = 2;

	typedef enum logic [1:0] {
		SPEED_FASTEST = 2'b00,
		SPEED_MEDIUM  = 2'b01,
		SPEED_LOW     = 2'b10,
		SPEED_SLOWEST = 2'b11
	} speed_t;

endpackage

//--- cmp_sync_if.sv
// Purpose: Carries the raw comparator level into the synchroniser and its results back.
// Assumes: One clock domain on the user side.
// Notes:   Rise and fall are one-cycle pulses.

`timescale 1ns/1ps

interface cmp_sync_if;
	logic rawLevel;
	logic syncLevel;
	logic rise;
	logic fall;

	modport sync_side (input rawLevel, output syncLevel, output rise, output fall);
	modport user_side (output rawLevel, input syncLevel, input rise, input fall);
endinterface

//--- cmp_sync_edge.sv
// Purpose: Two-flop synchroniser with edge detection for the comparator level.
// Assumes: Raw level is asynchronous to clk.
// Notes:   Edges are taken from the second stage only.

`timescale 1ns/1ps

module cmp_sync_edge (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level and edges
	cmp_sync_if.sync_side sif
);

	logic stage1;
	logic stage2;
	logic previous;
	logic next_stage1;
	logic next_stage2;
	logic next_previous;

	// -------------------------------------------------------------------
	// Synchroniser
	// -------------------------------------------------------------------
	// The first stage feeds only the second stage, to keep metastability contained.
	always_comb begin
		next_stage1   = sif.rawLevel;
		next_stage2   = stage1;
		next_previous = stage2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= 1'b0;
			stage2   <= 1'b0;
			previous <= 1'b0;
		end else begin
			stage1   <= next_stage1;
			stage2   <= next_stage2;
			previous <= next_previous;
		end
	end

	assign sif.syncLevel = stage2;
	assign sif.rise      = stage2 & ~previous;
	assign sif.fall      = ~stage2 & previous;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	a_sync_two_flop: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n, 3) |-> sif.syncLevel == $past(sif.rawLevel, 2))
		else $error("Synchronised level does not follow raw level after two cycles.");

	a_sync_edge_once: assert property (@(posedge clk) disable iff (!rst_n)
		sif.rise |=> !sif.rise)
		else $error("Rise pulse lasted more than one cycle.");

endmodule

//--- comparator_output_control.sv
// Purpose: Register file and output conditioning around an analog comparator.
// Assumes: APB master per the usual protocol; comparator output arrives asynchronously.
// Notes:   Output path from comparator to pins is combinational and needs no clock.

`timescale 1ns/1ps

module comparator_output_control (
	// Clock and resets
	input  wire  logic                  clk,
	input  wire  logic                  rst_n,
	input  wire  logic                  periphReset,
	input  wire  logic                  periphClockEnable,
	// APB slave
	input  wire  logic [11:0]           paddr,
	input  wire  logic                  psel,
	input  wire  logic                  penable,
	input  wire  logic                  pwrite,
	input  wire  logic [31:0]           pwdata,
	output logic       [31:0]           prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Analog core
	input  wire  logic                  comparatorRaw,
	output logic                        compEnable,
	output comparator_pkg::speed_t      speedPower,
	output logic       [1:0]            hysteresisLevel,
	output logic       [2:0]            plusInputSelect,
	output logic       [2:0]            minusInputSelect,
	output logic       [2:0]            minusExtraSelect,
	output logic                        referenceOutputEnable,
	output logic                        dividerBridgeEnable,
	// Blanking sources
	input  wire  logic                  blankSourceA,
	input  wire  logic                  blankSourceB,
	input  wire  logic                  blankSourceC,
	// Conditioned output consumers
	output logic                        outputPin,
	output logic                        extInterruptLine,
	output logic                        triggerSelectorOut,
	output logic                        timerTriggerOut,
	output logic                        firstTimerCapture,
	output logic                        secondTimerCapture,
	// Interrupt
	output logic                        irq
);

	logic [31:0]                            controlStatus;
	logic [31:0]                            next_controlStatus;
	logic [comparator_pkg::INT_WIDTH-1:0]   intStatus;
	logic [comparator_pkg::INT_WIDTH-1:0]   next_intStatus;
	logic [comparator_pkg::INT_WIDTH-1:0]   intEnable;
	logic [comparator_pkg::INT_WIDTH-1:0]   next_intEnable;
	logic [comparator_pkg::INT_WIDTH-1:0]   intEvents;
	logic [comparator_pkg::INT_WIDTH-1:0]   intClear;
	logic                                   busActive;
	logic                                   writeStrobe;
	logic                                   mapped;
	logic                                   locked;
	logic [2:0]                             blankSelect;
	logic                                   blankSignal;
	logic                                   blankedOutput;
	logic                                   finalOutput;
	logic [1:0]                             outSelect;

	cmp_sync_if syncBus ();

	// -------------------------------------------------------------------
	// Synchroniser for the status bit and edge events
	// -------------------------------------------------------------------
	assign syncBus.rawLevel = comparatorRaw;

	cmp_sync_edge syncEdge (
		.clk   (clk),
		.rst_n (rst_n),
		.sif   (syncBus.sync_side)
	);

	// -------------------------------------------------------------------
	// APB decode
	// -------------------------------------------------------------------
	// Gating by the private enable models the block's own clock gate without stopping clk.
	assign busActive   = psel & periphClockEnable;
	assign writeStrobe = busActive & penable & pwrite;
	assign pready      = 1'b1;
	assign locked      = controlStatus[comparator_pkg::LOCK_BIT];

	always_comb begin
		mapped = (paddr == comparator_pkg::CS_OFFSET) ||
			(paddr == comparator_pkg::INT_STATUS_OFFSET) ||
			(paddr == comparator_pkg::INT_CLEAR_OFFSET) ||
			(paddr == comparator_pkg::INT_ENABLE_OFFSET);
	end

	assign pslverr = psel & penable & ~mapped;

	always_comb begin
		prdata = 32'h00000000;
		if (busActive && !pwrite) begin
			case (paddr)
				comparator_pkg::CS_OFFSET: begin
					prdata = controlStatus;
					prdata[comparator_pkg::STATE_BIT] = syncBus.syncLevel;
				end
				comparator_pkg::INT_STATUS_OFFSET: begin
					prdata[comparator_pkg::INT_WIDTH-1:0] = intStatus;
				end
				comparator_pkg::INT_ENABLE_OFFSET: begin
					prdata[comparator_pkg::INT_WIDTH-1:0] = intEnable;
				end
				default: begin
					prdata = 32'h00000000;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Control/status register
	// -------------------------------------------------------------------
	always_comb begin
		next_controlStatus = controlStatus;
		if (periphReset) begin
			next_controlStatus = comparator_pkg::CS_RESET;
		end else if (writeStrobe && paddr == comparator_pkg::CS_OFFSET && !locked) begin
			next_controlStatus = pwdata & comparator_pkg::CS_WRITE_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			controlStatus <= comparator_pkg::CS_RESET;
		end else begin
			controlStatus <= next_controlStatus;
		end
	end

	// -------------------------------------------------------------------
	// Analog controls
	// -------------------------------------------------------------------
	assign compEnable            = controlStatus[comparator_pkg::ENABLE_BIT];
	assign speedPower            = comparator_pkg::speed_t'(controlStatus[comparator_pkg::SPEED_LSB +: 2]);
	assign hysteresisLevel       = controlStatus[comparator_pkg::HYST_LSB +: 2];
	assign plusInputSelect       = controlStatus[comparator_pkg::PLUS_SEL_LSB +: 3];
	assign minusInputSelect      = controlStatus[comparator_pkg::MINUS_SEL_LSB +: 3];
	assign minusExtraSelect      = controlStatus[comparator_pkg::MINUS_EXT_LSB +: 3];
	assign referenceOutputEnable = controlStatus[comparator_pkg::SCALER_EN_BIT];
	assign dividerBridgeEnable   = controlStatus[comparator_pkg::BRIDGE_EN_BIT];

	// -------------------------------------------------------------------
	// Output conditioning
	// -------------------------------------------------------------------
	// No flop sits on this path, so the pin keeps working while the bus clock is stopped.
	assign blankSelect = controlStatus[comparator_pkg::BLANK_LSB +: 3];
	assign outSelect   = controlStatus[comparator_pkg::OUT_SEL_LSB +: 2];

	always_comb begin
		case (blankSelect)
			comparator_pkg::BLANK_SRC_A: blankSignal = blankSourceA;
			comparator_pkg::BLANK_SRC_B: blankSignal = blankSourceB;
			comparator_pkg::BLANK_SRC_C: blankSignal = blankSourceC;
			default:                     blankSignal = 1'b0;
		endcase
	end

	assign blankedOutput      = comparatorRaw & ~blankSignal;
	assign finalOutput        = blankedOutput ^ controlStatus[comparator_pkg::POLARITY_BIT];
	assign outputPin          = finalOutput;
	assign extInterruptLine   = finalOutput;
	assign triggerSelectorOut = finalOutput;
	assign timerTriggerOut    = finalOutput;
	assign firstTimerCapture  = finalOutput & (outSelect == comparator_pkg::OUT_SEL_FIRST);
	assign secondTimerCapture = finalOutput & (outSelect == comparator_pkg::OUT_SEL_SECOND);

	// -------------------------------------------------------------------
	// Interrupt status, clear and enable
	// -------------------------------------------------------------------
	always_comb begin
		intEvents = '0;
		intEvents[comparator_pkg::INT_RISE_BIT] = syncBus.rise;
		intEvents[comparator_pkg::INT_FALL_BIT] = syncBus.fall;
		intClear = '0;
		if (writeStrobe && paddr == comparator_pkg::INT_CLEAR_OFFSET) begin
			intClear = pwdata[comparator_pkg::INT_WIDTH-1:0];
		end
	end

	// A new edge in the clearing cycle survives, since the set term is applied last.
	always_comb begin
		next_intStatus = (intStatus & ~intClear) | intEvents;
		next_intEnable = intEnable;
		if (writeStrobe && paddr == comparator_pkg::INT_ENABLE_OFFSET) begin
			next_intEnable = pwdata[comparator_pkg::INT_WIDTH-1:0];
		end
		if (periphReset) begin
			next_intStatus = comparator_pkg::INT_RESET;
			next_intEnable = comparator_pkg::INT_RESET;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intStatus <= comparator_pkg::INT_RESET;
			intEnable <= comparator_pkg::INT_RESET;
		end else begin
			intStatus <= next_intStatus;
			intEnable <= next_intEnable;
		end
	end

	assign irq = |(intStatus & intEnable);

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	a_lock_freezes_cs: assert property (@(posedge clk) disable iff (!rst_n)
		(locked && !periphReset) |=> $stable(controlStatus))
		else $error("Control word changed while locked.");

	a_cs_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		(writeStrobe && paddr == comparator_pkg::CS_OFFSET && !locked && !periphReset)
		|=> controlStatus == ($past(pwdata) & comparator_pkg::CS_WRITE_MASK))
		else $error("Unlocked write did not land in the control word.");

	a_gated_no_write: assert property (@(posedge clk) disable iff (!rst_n)
		(!periphClockEnable && !periphReset) |=> $stable(controlStatus) && $stable(intEnable))
		else $error("Register changed while access was disabled.");

	a_blank_and_pol: assert property (@(posedge clk) disable iff (!rst_n)
		outputPin == ((comparatorRaw & ~blankSignal) ^ controlStatus[comparator_pkg::POLARITY_BIT]))
		else $error("Pin output does not match blanked and polarised raw output.");

	a_reserved_no_blank: assert property (@(posedge clk) disable iff (!rst_n)
		(blankSelect[2] || blankSelect == comparator_pkg::BLANK_NONE)
		|-> outputPin == (comparatorRaw ^ controlStatus[comparator_pkg::POLARITY_BIT]))
		else $error("Blanking applied with an idle or reserved code.");

	a_polarity_invert: assert property (@(posedge clk) disable iff (!rst_n)
		(controlStatus[comparator_pkg::POLARITY_BIT] && blankSignal == 1'b0) |-> outputPin != comparatorRaw)
		else $error("Polarity one did not invert the output.");

	a_all_sinks_same: assert property (@(posedge clk) disable iff (!rst_n)
		extInterruptLine == outputPin && triggerSelectorOut == outputPin && timerTriggerOut == outputPin)
		else $error("Output consumers disagree.");

	a_capture_route: assert property (@(posedge clk) disable iff (!rst_n)
		firstTimerCapture == (outputPin && outSelect == comparator_pkg::OUT_SEL_FIRST) &&
		secondTimerCapture == (outputPin && outSelect == comparator_pkg::OUT_SEL_SECOND))
		else $error("Capture routing does not follow the output select field.");

	a_status_reads_sync: assert property (@(posedge clk) disable iff (!rst_n)
		(busActive && !pwrite && paddr == comparator_pkg::CS_OFFSET)
		|-> prdata[comparator_pkg::STATE_BIT] == syncBus.syncLevel)
		else $error("Status bit does not show the synchronised output.");

	a_rise_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(syncBus.rise && !periphReset) |=> intStatus[comparator_pkg::INT_RISE_BIT])
		else $error("Rising edge did not set its status flag.");

	a_speed_field: assert property (@(posedge clk) disable iff (!rst_n)
		speedPower == controlStatus[comparator_pkg::SPEED_LSB +: 2])
		else $error("Speed output does not match the control field.");

	a_fall_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(syncBus.fall && !periphReset) |=> intStatus[comparator_pkg::INT_FALL_BIT])
		else $error("Falling edge did not set its status flag.");

	a_clear_drops_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(intClear[comparator_pkg::INT_RISE_BIT] && !intEvents[comparator_pkg::INT_RISE_BIT])
		|=> !intStatus[comparator_pkg::INT_RISE_BIT])
		else $error("Writing one to the clear register left the rise flag set.");

	a_private_reset: assert property (@(posedge clk) disable iff (!rst_n)
		periphReset |=> controlStatus == comparator_pkg::CS_RESET && intEnable == comparator_pkg::INT_RESET)
		else $error("Private reset did not clear the registers.");

	a_state_not_stored: assert property (@(posedge clk) disable iff (!rst_n)
		controlStatus[comparator_pkg::STATE_BIT] == 1'b0)
		else $error("Read-only state bit was stored in the control word.");

	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		(|(intEvents & intEnable) && !periphReset && !writeStrobe) |=> irq)
		else $error("Enabled event did not raise the interrupt output.");

	c_lock_set: cover property (@(posedge clk) disable iff (!rst_n) $rose(locked));
	c_blank_active: cover property (@(posedge clk) disable iff (!rst_n)
		comparatorRaw && blankSignal && blankSelect != comparator_pkg::BLANK_NONE);
	c_irq_raised: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
	c_clear_with_event: cover property (@(posedge clk) disable iff (!rst_n) |(intClear & intEvents));
	c_locked_write: cover property (@(posedge clk) disable iff (!rst_n)
		writeStrobe && locked && paddr == comparator_pkg::CS_OFFSET);

endmodule

//--- cmp_far_side_model.sv
// Purpose: Far side of the comparator block: analog core level and the timer blanking channels.
// Assumes: The bench commands levels; this model launches them just after a rising edge.
// Notes:   Levels are held until the next command, as a real comparator would hold them.

`timescale 1ns/1ps

module cmp_far_side_model (
	// Clock
	input  wire logic       clk,
	// Commands from the bench
	input  wire logic       cmdRaw,
	input  wire logic [2:0] cmdBlank,
	// Levels toward the block
	output logic            comparatorRaw = 1'b0,
	output logic            blankSourceA  = 1'b0,
	output logic            blankSourceB  = 1'b0,
	output logic            blankSourceC  = 1'b0
);
	// Both levels change only after an edge, so the block never sees a change on its sampling edge.
	always @(posedge clk) begin
		comparatorRaw <= cmdRaw;
		{blankSourceC, blankSourceB, blankSourceA} <= cmdBlank;
	end
endmodule

//--- comparator_output_control_bench.sv
// Purpose: Self-checking bench for the comparator output control block.
// Assumes: Zero-wait APB slave; raw level reaches the status bit within a few edges.
// Notes:   Output routing is checked from a row table, registers by hand after it.

`timescale 1ns/1ps

module comparator_output_control_bench;
	typedef struct packed {
		logic raw; logic [2:0] blk; logic [2:0] srcs; logic pol; logic [1:0] osel; logic [1:0] speed;
		logic expOut; logic expT0; logic expT1;
	} row_t;
	logic        clk = 0, rst_n = 0, periphReset = 0, periphClockEnable = 1;
	logic [11:0] paddr = 12'h000;
	logic        psel = 0, penable = 0, pwrite = 0, lastErr, cmdRaw = 0;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [2:0]  cmdBlank = 3'h0, plusInputSelect, minusInputSelect, minusExtraSelect;
	logic [1:0]  hysteresisLevel;
	logic        pready, pslverr, compEnable, referenceOutputEnable, dividerBridgeEnable, irq;
	logic        outputPin, extInterruptLine, triggerSelectorOut, timerTriggerOut, firstTimerCapture;
	logic        secondTimerCapture, comparatorRaw, blankSourceA, blankSourceB, blankSourceC;
	comparator_pkg::speed_t speedPower;
	int          n_errors = 0, tests_run = 0, cycles = 0;
	row_t        rows [8];

	comparator_output_control u_comparator_output_control (.clk, .rst_n, .periphReset, .periphClockEnable,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .comparatorRaw, .compEnable,
		.speedPower, .hysteresisLevel, .plusInputSelect, .minusInputSelect, .minusExtraSelect,
		.referenceOutputEnable, .dividerBridgeEnable, .blankSourceA, .blankSourceB, .blankSourceC,
		.outputPin, .extInterruptLine, .triggerSelectorOut, .timerTriggerOut, .firstTimerCapture,
		.secondTimerCapture, .irq);
	cmp_far_side_model u_cmp_far_side_model (.clk, .cmdRaw, .cmdBlank, .comparatorRaw, .blankSourceA,
		.blankSourceB, .blankSourceC);

	always #2 clk = ~clk;

	// -------------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------------
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; read data and error are taken at the edge that samples pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	function automatic logic [31:0] csOf(input row_t r);
		return (32'(r.blk) << comparator_pkg::BLANK_LSB) | (32'(r.speed) << comparator_pkg::HYST_LSB)
			| (32'(r.pol) << comparator_pkg::POLARITY_BIT) | (32'(r.osel) << comparator_pkg::OUT_SEL_LSB)
			| (32'(r.speed) << comparator_pkg::SPEED_LSB) | 32'h00000001;
	endfunction

	// The limit sits far above the roughly 140 cycles that the sequence needs.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			print_verdict();
		end
	end

	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		rows = '{
			'{1'b1, 3'h0, 3'h7, 1'b0, 2'h1, 2'h0, 1'b1, 1'b1, 1'b0},
			'{1'b1, 3'h1, 3'h1, 1'b0, 2'h2, 2'h3, 1'b0, 1'b0, 1'b0},
			'{1'b1, 3'h2, 3'h1, 1'b0, 2'h2, 2'h1, 1'b1, 1'b0, 1'b1},
			'{1'b1, 3'h3, 3'h4, 1'b1, 2'h1, 2'h2, 1'b1, 1'b1, 1'b0},
			'{1'b0, 3'h0, 3'h0, 1'b1, 2'h2, 2'h0, 1'b1, 1'b0, 1'b1},
			'{1'b1, 3'h5, 3'h7, 1'b0, 2'h1, 2'h3, 1'b1, 1'b1, 1'b0},
			'{1'b1, 3'h7, 3'h7, 1'b1, 2'h3, 2'h0, 1'b0, 1'b0, 1'b0},
			'{1'b0, 3'h3, 3'h0, 1'b0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0}};
		repeat (20) @(posedge clk);
		rst_n <= 1;
		apb(0, comparator_pkg::CS_OFFSET, 0);
		check("cs reset", rd, comparator_pkg::CS_RESET);
		check("irq reset", irq, 0);
		foreach (rows[i]) begin
			apb(1, comparator_pkg::CS_OFFSET, csOf(rows[i]));
			@(posedge clk);
			cmdRaw <= rows[i].raw;
			cmdBlank <= rows[i].srcs;
			repeat (2) @(posedge clk);
			@(negedge clk);
			check("outputs", {outputPin, extInterruptLine, triggerSelectorOut, timerTriggerOut}, {4{rows[i].expOut}});
			check("captures", {firstTimerCapture, secondTimerCapture}, {rows[i].expT0, rows[i].expT1});
			check("speed", {speedPower, hysteresisLevel}, {2{rows[i].speed}});
		end
		apb(1, comparator_pkg::INT_CLEAR_OFFSET, 3);
		apb(0, comparator_pkg::INT_STATUS_OFFSET, 0);
		check("status cleared", rd, 0);
		apb(1, comparator_pkg::INT_ENABLE_OFFSET, 1);
		cmdRaw <= 1;
		repeat (6) @(posedge clk);
		check("irq rise", irq, 1);
		apb(0, comparator_pkg::CS_OFFSET, 0);
		check("state bit", rd, csOf(rows[7]) | 32'h40000000);
		apb(1, comparator_pkg::INT_CLEAR_OFFSET, 1);
		apb(0, comparator_pkg::INT_STATUS_OFFSET, 0);
		check("status after clear", {rd[1:0], irq}, 0);
		cmdRaw <= 0;
		repeat (6) @(posedge clk);
		apb(0, comparator_pkg::INT_STATUS_OFFSET, 0);
		check("masked fall", {rd[1:0], irq}, 3'h4);
		apb(0, 12'h010, 0);
		check("unmapped", {rd, lastErr}, 33'h1);
		apb(1, comparator_pkg::CS_OFFSET, 32'h80001f9d);
		apb(1, comparator_pkg::CS_OFFSET, 32'h00000000);
		apb(0, comparator_pkg::CS_OFFSET, 0);
		check("locked cs", rd, 32'h80001f9d);
		check("input selects", {plusInputSelect, minusInputSelect, minusExtraSelect}, 9'h1f9);
		check("enable bits", {compEnable, referenceOutputEnable, dividerBridgeEnable}, 3'h4);
		@(posedge clk);
		periphReset <= 1;
		@(posedge clk);
		periphReset <= 0;
		apb(0, comparator_pkg::CS_OFFSET, 0);
		check("unlocked cs", rd, 0);
		apb(1, comparator_pkg::CS_OFFSET, 32'h00c00000);
		apb(0, comparator_pkg::CS_OFFSET, 0);
		check("scaler cs", rd, 32'h00c00000);
		check("scaler enables", {compEnable, referenceOutputEnable, dividerBridgeEnable}, 3'h3);
		apb(1, comparator_pkg::INT_ENABLE_OFFSET, 1);
		periphClockEnable <= 0;
		apb(1, comparator_pkg::INT_ENABLE_OFFSET, 2);
		apb(0, comparator_pkg::INT_ENABLE_OFFSET, 0);
		check("gated read", rd, 0);
		periphClockEnable <= 1;
		apb(0, comparator_pkg::INT_ENABLE_OFFSET, 0);
		check("gated write", rd, 1);
		print_verdict();
	end
endmodule
